// ### rtl/rbs_readback.sv
// rbs_readback: serial readback engine for the stored configuration frames.
// assumes: frame memory answers o_frame_addr combinationally on i_clk; the
// readback clocks and trigger are asynchronous pins, sampled here on i_clk.
//
// How it works
// - trigger rise arms; flag rises, edges shift
// - five high dummies, then low start bit
// - first two frame data bits forced high
// - four check bits per frame read high
// - last seven bits of last frame high
// - final start bit, 11-bit signature, flag drops
// - signature is top 11 of CRC-16 CCITT
// - trigger latches inverted capture state
// - configuration bits uninverted, captures inverted
// - capture off returns written configuration values
// - memory tables return current memory contents
// - abort: trigger fall ends and disarms
// - flag high exactly while readback active
// - rising readback clock edges, clock selectable
// - next frame loaded six cycles before start
// - frame data held static between loads
// - trigger high at finish starts readback
`default_nettype none
module rbs_readback
    import rbs_pkg::*;
#(
    parameter int FRAME_DATA = rbs_pkg::DEF_FRAME_DATA,
    parameter int NUM_FRAMES = rbs_pkg::DEF_NUM_FRAMES,
    parameter int CAPTURE_BITS = rbs_pkg::DEF_CAPTURE_BITS,
    parameter int FIFO_DEPTH = rbs_pkg::DEF_FIFO_DEPTH,
    parameter int REINIT_CLOCKS = rbs_pkg::DEF_NUM_FRAMES
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_configuration_clock,
    input wire logic i_user_readback_clock,
    input wire logic i_use_user_clock,
    input wire logic i_readback_trigger,
    input wire logic i_config_finished,
    input wire logic i_capture_enable,
    input wire logic i_abort_enable,
    input wire logic [FRAME_DATA-1:0] i_frame_data,
    input wire logic [FRAME_DATA-1:0] i_capture_mask,
    input wire logic [CAPTURE_BITS-1:0] i_capture_state,
    output logic [rbs_pkg::CNT_WIDTH-1:0] o_frame_addr,
    output logic o_frame_read,
    output logic o_readback_data,
    output logic o_readback_in_progress
);
    import rbs_pkg::*;

    localparam int SHW = FRAME_DATA + CHECK_BITS;
    localparam int FRAME_LEN = 1 + SHW;
    localparam logic [CNT_WIDTH-1:0] LOAD_AT = CNT_WIDTH'(FRAME_LEN - LOAD_CYCLES);
    localparam logic [CNT_WIDTH-1:0] FRAME_LAST = CNT_WIDTH'(FRAME_LEN - 1);
    localparam logic [CNT_WIDTH-1:0] LAST_FRAME = CNT_WIDTH'(NUM_FRAMES - 1);
    localparam logic [CNT_WIDTH-1:0] DUMMY_LAST = CNT_WIDTH'(DUMMY_BITS - 1);
    localparam logic [CNT_WIDTH-1:0] SIG_LAST = CNT_WIDTH'(SIGNATURE_BITS - 1);
    localparam logic [CNT_WIDTH-1:0] REINIT_LAST = CNT_WIDTH'(REINIT_CLOCKS - 1);

    initial begin
        if (SHW < LOAD_CYCLES || FRAME_DATA < LAST_HIGH_BITS || NUM_FRAMES < 1
                || REINIT_CLOCKS < 1 || CAPTURE_BITS < 1
                || FRAME_LEN >= (1 << CNT_WIDTH) || NUM_FRAMES >= (1 << CNT_WIDTH)) begin
            $error("rbs_readback: parameter values cannot be served");
        end
    end

    // ****************************************
    // helper functions
    // ****************************************
    function automatic logic [CRC_WIDTH-1:0] crc_step(input logic [CRC_WIDTH-1:0] c,
                                                      input logic b);
        logic fb;
        fb = c[CRC_WIDTH-1] ^ b;
        crc_step = {c[CRC_WIDTH-2:0], 1'b0} ^ (fb ? CRC_POLY : '0);
    endfunction

    function automatic int count_ones(input logic [FRAME_DATA-1:0] m);
        int n;
        n = 0;
        for (int i = 0; i < FRAME_DATA; i++) begin
            n = n + int'(m[i]);
        end
        count_ones = n;
    endfunction

    // capture positions take snapshot bits in order, MSB position first
    function automatic logic [FRAME_DATA-1:0] merge_capture(
            input logic [FRAME_DATA-1:0] cfg,
            input logic [FRAME_DATA-1:0] mask,
            input logic [CAPTURE_BITS-1:0] snap);
        logic [FRAME_DATA-1:0] r;
        int j;
        r = cfg;
        j = 0;
        for (int i = FRAME_DATA - 1; i >= 0; i--) begin
            if (mask[i] && j < CAPTURE_BITS) begin
                r[i] = snap[j];
                j = j + 1;
            end
        end
        merge_capture = r;
    endfunction

    // forced-high positions applied as the frame enters the stage register
    function automatic logic [SHW-1:0] shape_frame(input logic [FRAME_DATA-1:0] d,
                                                   input logic first,
                                                   input logic last);
        logic [SHW-1:0] r;
        r = {d, {CHECK_BITS{1'b1}}};
        if (first) begin
            r[SHW-1 -: FIRST_HIGH_BITS] = '1;
        end
        if (last) begin
            r[LAST_HIGH_BITS-1:0] = '1;
        end
        shape_frame = r;
    endfunction

    // ****************************************
    // pin synchronisers and edge detection
    // ****************************************
    logic cfg_clk_a;
    logic cfg_clk_b;
    logic usr_clk_a;
    logic usr_clk_b;
    logic rclk_d;
    logic trig_a;
    logic trig_b;
    logic trig_d;
    logic fin_d;
    logic rclk_sel;
    logic rclk_rise;
    logic trig_rise;
    logic trig_fall;
    logic start_evt;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            cfg_clk_a <= 1'b0;
            cfg_clk_b <= 1'b0;
            usr_clk_a <= 1'b0;
            usr_clk_b <= 1'b0;
            trig_a <= 1'b0;
            trig_b <= 1'b0;
        end else begin
            cfg_clk_a <= i_configuration_clock;
            cfg_clk_b <= cfg_clk_a;
            usr_clk_a <= i_user_readback_clock;
            usr_clk_b <= usr_clk_a;
            trig_a <= i_readback_trigger;
            trig_b <= trig_a;
        end
    end

    assign rclk_sel = i_use_user_clock ? usr_clk_b : cfg_clk_b;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rclk_d <= 1'b0;
            trig_d <= 1'b0;
            fin_d <= 1'b0;
        end else begin
            rclk_d <= rclk_sel;
            trig_d <= trig_b;
            fin_d <= i_config_finished;
        end
    end

    assign rclk_rise = rclk_sel && !rclk_d;
    assign trig_rise = trig_b && !trig_d;
    assign trig_fall = !trig_b && trig_d;
    assign start_evt = trig_rise || (i_config_finished && !fin_d && trig_b);

    // ****************************************
    // arming and capture snapshot
    // ****************************************
    rbs_state_t state;
    logic pending;
    logic abort_evt;
    logic arm_evt;
    logic [CAPTURE_BITS-1:0] snap;

    assign arm_evt = start_evt && state == RBS_IDLE && !pending;
    assign abort_evt = i_abort_enable && trig_fall && (pending || o_readback_in_progress);

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            pending <= 1'b0;
        end else if (abort_evt) begin
            pending <= 1'b0;
        end else if (arm_evt) begin
            pending <= 1'b1;
        end else if (rclk_rise && state == RBS_IDLE) begin
            pending <= 1'b0;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            snap <= '0;
        end else if (arm_evt) begin
            snap <= ~i_capture_state;
        end else if (o_frame_read) begin
            snap <= snap >> count_ones(i_capture_mask);
        end
    end

    // ****************************************
    // frame fetch into the FIFO
    // ****************************************
    logic fetch_active;
    logic fifo_in_ready;
    logic fifo_out_valid;
    logic [FRAME_DATA-1:0] fifo_out;
    logic [FRAME_DATA-1:0] fetch_word;
    logic pop;

    assign o_frame_read = fetch_active && fifo_in_ready && !abort_evt;
    assign fetch_word = i_capture_enable
        ? merge_capture(i_frame_data, i_capture_mask, snap) : i_frame_data;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            fetch_active <= 1'b0;
            o_frame_addr <= '0;
        end else if (abort_evt) begin
            fetch_active <= 1'b0;
        end else if (arm_evt) begin
            fetch_active <= 1'b1;
            o_frame_addr <= '0;
        end else if (o_frame_read) begin
            o_frame_addr <= o_frame_addr + 1'b1;
            if (o_frame_addr == LAST_FRAME) begin
                fetch_active <= 1'b0;
            end
        end
    end

    // the FIFO decouples the fast fetch from the slow readback clock
    rbs_fifo #(
        .WIDTH(FRAME_DATA),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .i_clk(i_clk),
        .i_rst(i_rst),
        .i_flush(abort_evt),
        .i_in_valid(fetch_active),
        .o_in_ready(fifo_in_ready),
        .i_in_data(fetch_word),
        .o_out_valid(fifo_out_valid),
        .i_out_ready(pop),
        .o_out_data(fifo_out)
    );

    // ****************************************
    // serial stream
    // ****************************************
    logic [CNT_WIDTH-1:0] cnt;
    logic [CNT_WIDTH-1:0] frame_no;
    logic [SHW-1:0] stage;
    logic [SHW-1:0] shf;
    logic [CRC_WIDTH-1:0] crc;
    logic first_pop;
    logic later_pop;

    assign first_pop = rclk_rise && state == RBS_IDLE && pending;
    assign later_pop = rclk_rise && state == RBS_FRAME && cnt == LOAD_AT
        && frame_no != LAST_FRAME;
    assign pop = (first_pop || later_pop) && fifo_out_valid && !abort_evt;

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            stage <= '1;
        end else if (pop) begin
            stage <= shape_frame(fifo_out, first_pop,
                                 first_pop ? (LAST_FRAME == '0) : (frame_no + 1'b1 == LAST_FRAME));
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            state <= RBS_IDLE;
            cnt <= '0;
            frame_no <= '0;
            shf <= '1;
            crc <= CRC_INIT;
            o_readback_data <= IDLE_LEVEL;
            o_readback_in_progress <= 1'b0;
        end else if (abort_evt) begin
            state <= RBS_REINIT;
            cnt <= '0;
            o_readback_data <= IDLE_LEVEL;
            o_readback_in_progress <= 1'b0;
        end else if (rclk_rise) begin
            case (state)
                RBS_IDLE: begin
                    o_readback_data <= IDLE_LEVEL;
                    if (pending) begin
                        o_readback_in_progress <= 1'b1;
                        state <= RBS_DUMMY;
                        cnt <= '0;
                        frame_no <= '0;
                        crc <= CRC_INIT;
                    end else begin
                        // flag drops after signature
                        // held through the last signature bit so the controller still sees it
                        o_readback_in_progress <= 1'b0;
                    end
                end
                RBS_DUMMY: begin
                    o_readback_data <= 1'b1;
                    if (cnt == DUMMY_LAST) begin
                        state <= RBS_FRAME;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                RBS_FRAME: begin
                    if (cnt == '0) begin
                        o_readback_data <= START_BIT;
                        shf <= stage;
                    end else begin
                        o_readback_data <= shf[SHW-1];
                        shf <= {shf[SHW-2:0], 1'b1};
                        crc <= crc_step(crc, shf[SHW-1]);
                    end
                    if (cnt == FRAME_LAST) begin
                        cnt <= '0;
                        if (frame_no == LAST_FRAME) begin
                            state <= RBS_CRC_START;
                        end else begin
                            frame_no <= frame_no + 1'b1;
                        end
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                RBS_CRC_START: begin
                    o_readback_data <= START_BIT;
                    state <= RBS_CRC;
                    cnt <= '0;
                end
                RBS_CRC: begin
                    o_readback_data <= crc[CRC_WIDTH-1];
                    crc <= {crc[CRC_WIDTH-2:0], 1'b0};
                    if (cnt == SIG_LAST) begin
                        state <= RBS_IDLE;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                RBS_REINIT: begin
                    o_readback_data <= IDLE_LEVEL;
                    if (cnt == REINIT_LAST) begin
                        state <= RBS_IDLE;
                        cnt <= '0;
                    end else begin
                        cnt <= cnt + 1'b1;
                    end
                end
                default: begin
                    state <= RBS_IDLE;
                    o_readback_in_progress <= 1'b0;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// ### rtl/rbs_pkg.sv
// rbs_pkg: shared constants and types of the configuration readback serializer.
// assumes: included before rtl/rbs_fifo.sv and rtl/rbs_readback.sv.
`default_nettype none
package rbs_pkg;
    // ****************************************
    // stream layout
    // ****************************************
    localparam int DUMMY_BITS = 5;
    localparam int FIRST_HIGH_BITS = 2;
    localparam int CHECK_BITS = 4;
    localparam int LAST_HIGH_BITS = 7;
    localparam int SIGNATURE_BITS = 11;
    localparam int LOAD_CYCLES = 6;
    localparam logic START_BIT = 1'b0;
    localparam logic IDLE_LEVEL = 1'b1;
    // ****************************************
    // checksum
    // ****************************************
    localparam int CRC_WIDTH = 16;
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'h0000;
    // ****************************************
    // default sizes
    // ****************************************
    localparam int DEF_FRAME_DATA = 32;
    localparam int DEF_NUM_FRAMES = 8;
    localparam int DEF_CAPTURE_BITS = 16;
    localparam int DEF_FIFO_DEPTH = 16;
    localparam int CNT_WIDTH = 16;

    typedef enum logic [2:0] {
        RBS_IDLE,
        RBS_DUMMY,
        RBS_FRAME,
        RBS_CRC_START,
        RBS_CRC,
        RBS_REINIT
    } rbs_state_t;
endpackage
`default_nettype wire

// ### rtl/rbs_fifo.sv
// rbs_fifo: flip-flop FIFO with valid/ready on both sides and a flush.
// assumes: one clock, producer and consumer on that clock.
`default_nettype none
module rbs_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    initial begin
        if (DEPTH < 2 || WIDTH < 1) begin
            $error("rbs_fifo: DEPTH must be at least 2 and WIDTH at least 1");
        end
    end

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign o_in_ready = (count != (AW+1)'(DEPTH));
    assign o_out_valid = (count != '0);
    assign o_out_data = mem[rd_ptr];
    assign push = i_in_valid && o_in_ready && !i_flush;
    assign pop = o_out_valid && i_out_ready && !i_flush;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(DEPTH - 1)) ? '0 : AW'(p + 1'b1);
    endfunction

    always_ff @(posedge i_clk) begin
        if (push) begin
            mem[wr_ptr] <= i_in_data;
        end
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else if (i_flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wr_ptr <= bump(wr_ptr);
            end
            if (pop) begin
                rd_ptr <= bump(rd_ptr);
            end
            if (push && !pop) begin
                count <= count + 1'b1;
            end else if (pop && !push) begin
                count <= count - 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### bench/rbs_readback_assertions.sv
// rbs_readback_assertions: stream-shape checks on the readback engine's pins.
// assumes: bound to rbs_readback; readback clock far slower than i_clk.
`default_nettype none
module rbs_readback_assertions #(
    parameter int FRAME_DATA = 32,
    parameter int NUM_FRAMES = 8
) (
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_configuration_clock,
    input wire logic i_user_readback_clock,
    input wire logic i_use_user_clock,
    input wire logic i_readback_trigger,
    input wire logic i_abort_enable,
    input wire logic o_readback_data,
    input wire logic o_readback_in_progress
);
    localparam int FL = FRAME_DATA + 5;
    localparam int LAST = 6 + NUM_FRAMES * FL;
    logic [2:0] ck_s;
    logic [2:0] tg_s;
    logic [3:0] since;
    logic [15:0] edges;
    logic [15:0] pos;
    logic rise;
    logic settled;
    // ****************************************
    // own view of the readback clock
    // ****************************************
    assign rise = ck_s[1] && !ck_s[2];
    assign pos = (edges >= 16'd6) ? (edges - 16'd6) % 16'(FL) : 16'hFFFF;
    // sample mid-bit so sync latency never matters
    assign settled = o_readback_in_progress && since == 4'd8;
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            ck_s <= 3'h0;
            tg_s <= 3'h0;
        end else begin
            ck_s <= {ck_s[1:0], i_use_user_clock ? i_user_readback_clock : i_configuration_clock};
            tg_s <= {tg_s[1:0], i_readback_trigger};
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            since <= 4'hF;
        end else if (rise) begin
            since <= 4'h0;
        end else if (since != 4'hF) begin
            since <= since + 4'h1;
        end
    end
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            edges <= 16'h0;
        end else if (!o_readback_in_progress) begin
            edges <= 16'h0;
        end else if (rise) begin
            edges <= edges + 16'h1;
        end
    end
    // ****************************************
    // properties
    // ****************************************
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    idle_data_high_a: assert property (!o_readback_in_progress &&
        !$past(o_readback_in_progress, 3) |-> o_readback_data) else $error("idle data low");
    data_on_edge_a: assert property (o_readback_in_progress &&
        $changed(o_readback_data) |-> since <= 4'd6) else $error("data moved off edge");
    flag_on_edge_a: assert property ($rose(o_readback_in_progress)
        |-> since <= 4'd6) else $error("flag rose off edge");
    dummy_high_a: assert property (settled && edges >= 1 && edges <= 5
        |-> o_readback_data) else $error("dummy bit low");
    start_bit_a: assert property (settled && edges >= 6 && edges <= LAST && pos == 0
        |-> !o_readback_data) else $error("start bit high");
    first_two_a: assert property (settled && (edges == 7 || edges == 8)
        |-> o_readback_data) else $error("first data bits low");
    check_bits_a: assert property (settled && edges > 6 && edges < LAST
        && pos > FRAME_DATA |-> o_readback_data) else $error("check bit low");
    last_seven_a: assert property (settled && edges >= LAST - 7 && edges < LAST
        |-> o_readback_data) else $error("last frame tail low");
    flag_end_a: assert property ($fell(o_readback_in_progress) && !i_abort_enable
        |-> edges == 16'(LAST + 12)) else $error("flag fell at wrong bit");
    abort_stop_a: assert property (i_abort_enable && o_readback_in_progress
        && !tg_s[1] && tg_s[2] |-> ##[0:4] !o_readback_in_progress) else $error("abort ignored");
endmodule
bind rbs_readback rbs_readback_assertions #(
    .FRAME_DATA(FRAME_DATA),
    .NUM_FRAMES(NUM_FRAMES)
) i_rbs_readback_assertions (
    .i_clk,
    .i_rst,
    .i_configuration_clock,
    .i_user_readback_clock,
    .i_use_user_clock,
    .i_readback_trigger,
    .i_abort_enable,
    .o_readback_data,
    .o_readback_in_progress
);
`default_nettype wire

// ### bench/rbs_ctl_model.sv
// rbs_ctl_model: readback controller driving the trigger and readback clock pins.
// assumes: tasks are called from one bench process.
`default_nettype none
module rbs_ctl_model (
    output logic o_rb_clk,
    output logic o_trigger
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_rb_clk = 1'b0;
        o_trigger = 1'b0;
    end
    // steady clock near boundaries
    // clock rests low between bursts; callers pause only mid-frame
    // the 1 ns offset keeps pin edges off the system clock edges
    task automatic burst(input int n);
        #1;
        repeat (n) begin
            o_rb_clk = 1'b1;
            #62.5;
            o_rb_clk = 1'b0;
            #62.5;
        end
    endtask
    // trigger held past its setup and hold window
    task automatic set_trig(input logic v);
        o_trigger = v;
        #250;
    endtask
endmodule
`default_nettype wire

// ### bench/test_config_readback_serializer.sv
// test_config_readback_serializer: readback runs, abort and capture.
// assumes: rbs_ctl_model plays the controller; frame memory modelled here.
`default_nettype none
module test_config_readback_serializer import rbs_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst, fin, use_u, cap_en, ab_en, dat, rip;
    logic [3:0] cs, snap;
    logic [7:0] mem [2];
    logic [7:0] cmask [2];
    logic [15:0] addr;
    logic [31:0] seed;
    logic [1:0] q[$];
    wire logic pclk, trig;
    int n_mismatch, n_tests;
    rbs_readback #(.FRAME_DATA(8), .NUM_FRAMES(2), .CAPTURE_BITS(4), .FIFO_DEPTH(16),
        .REINIT_CLOCKS(2)) i_rbs_readback (
        .i_clk(clk), .i_rst(rst), .i_configuration_clock(pclk & ~use_u),
        .i_user_readback_clock(pclk & use_u), .i_use_user_clock(use_u),
        .i_readback_trigger(trig), .i_config_finished(fin), .i_capture_enable(cap_en),
        .i_abort_enable(ab_en), .i_frame_data(mem[addr[0]]),
        .i_capture_mask(cmask[addr[0]]), .i_capture_state(cs),
        .o_frame_addr(addr), .o_frame_read(), .o_readback_data(dat),
        .o_readback_in_progress(rip));
    rbs_ctl_model i_rbs_ctl_model (.o_rb_clk(pclk), .o_trigger(trig));
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    task automatic cmp(input logic [1:0] g, input logic [1:0] e);
        n_tests++;
        if (g !== e) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic summarize();
        $display("counts: tests=%0d mismatches=%0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction
    task automatic fill();
        for (int f = 0; f < 2; f++) begin
            repeat (8) seed = lfsr(seed);
            mem[f] = seed[7:0];
            cmask[f] = seed[15:8] & (f ? 8'hC0 : 8'h30);
        end
    endtask
    // ****************************************
    // expected stream, one entry per clock rise
    // ****************************************
    task automatic expect_run(input logic cap);
        logic [15:0] crc;
        logic [11:0] w;
        logic [7:0] m;
        int k;
        crc = CRC_INIT;
        k = 0;
        q.push_back(2'b01);
        repeat (DUMMY_BITS + 1) q.push_back(2'b11);
        q.push_back(2'b10);
        for (int f = 0; f < 2; f++) begin
            w = {mem[f], 4'hF};
            m = cmask[f];
            for (int i = 7; i >= 0; i--) begin
                if (cap && m[i]) begin
                    w[i + 4] = ~snap[k];
                    k++;
                end
            end
            if (f == 0) w[11:10] = 2'b11;
            else w[6:0] = 7'h7F;
            for (int i = 11; i >= 0; i--) begin
                q.push_back({1'b1, w[i]});
                crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ w[i]) ? CRC_POLY : 16'h0000);
            end
            q.push_back(2'b10);
        end
        for (int i = 15; i >= 5; i--) q.push_back({1'b1, crc[i]});
        q.push_back(2'b01);
    endtask
    task automatic drain();
        for (int i = 0; i < 100 && q.size() > 0; i++) @(posedge clk);
        cmp({1'b0, q.size() == 0}, 2'b01);
    endtask
    // controller samples at each rise, before that edge's bit lands
    always @(posedge pclk) begin
        if (q.size() > 0) begin
            cmp({rip, dat}, q.pop_front());
        end
    end
    initial begin
        repeat (100000) @(posedge clk);
        n_mismatch++;
        summarize();
    end
    initial begin
        rst = 1'b1;
        {fin, use_u, cap_en, ab_en} = 4'h0;
        cs = 4'h0;
        snap = 4'h0;
        n_mismatch = 0;
        n_tests = 0;
        seed = 32'h3153;
        mem[0] = 8'h00;
        mem[1] = 8'h00;
        repeat (6) @(posedge clk);
        @(negedge clk);
        rst = 1'b0;
        fill();
        cmp({rip, dat}, 2'b01);
        i_rbs_ctl_model.set_trig(1'b1);
        @(negedge clk);
        fin = 1'b1;
        expect_run(1'b0);
        repeat (10) @(negedge clk);
        i_rbs_ctl_model.burst(10);
        // stray trigger edges during a mid-frame pause
        i_rbs_ctl_model.set_trig(1'b0);
        i_rbs_ctl_model.set_trig(1'b1);
        repeat (300) @(negedge clk);
        i_rbs_ctl_model.burst(36);
        drain();
        $display("test plain readback done");
        @(negedge clk);
        ab_en = 1'b1;
        fill();
        i_rbs_ctl_model.set_trig(1'b0);
        i_rbs_ctl_model.set_trig(1'b1);
        i_rbs_ctl_model.burst(8);
        cmp({1'b0, rip}, 2'b01);
        i_rbs_ctl_model.set_trig(1'b0);
        repeat (10) @(negedge clk);
        cmp({rip, dat}, 2'b01);
        i_rbs_ctl_model.burst(2);
        $display("test abort done");
        @(negedge clk);
        {ab_en, use_u, cap_en} = 3'b011;
        seed = lfsr(seed);
        cs = seed[3:0];
        snap = seed[3:0];
        fill();
        i_rbs_ctl_model.set_trig(1'b1);
        @(negedge clk);
        cs = ~cs;
        expect_run(1'b1);
        i_rbs_ctl_model.burst(46);
        drain();
        $display("test capture readback done");
        summarize();
    end
endmodule
`default_nettype wire
